/* File: design/pcg_pkg.sv */
// Package with the register map, field positions and pin types of the PWM generator.
package pcg_pkg;
	localparam logic [5:0] OFS_CTRL  = 6'h00;
	localparam logic [5:0] OFS_DUTY  = 6'h04;
	localparam logic [5:0] OFS_PHASE = 6'h08;
	localparam logic [5:0] OFS_DT    = 6'h0C;
	localparam logic [5:0] OFS_ALTDT = 6'h10;
	localparam logic [5:0] OFS_TRGC  = 6'h14;
	localparam logic [5:0] OFS_IOC   = 6'h18;
	localparam logic [5:0] OFS_TRIG  = 6'h1C;
	localparam logic [5:0] OFS_MDUTY = 6'h20;
	localparam logic [5:0] OFS_UNLK  = 6'h24;

	// Control register fields.
	localparam int B_FLTSTAT = 15;
	localparam int B_CLSTAT  = 14;
	localparam int B_TRGSTAT = 13;
	localparam int B_FLTIEN  = 12;
	localparam int B_CLIEN   = 11;
	localparam int B_TRGIEN  = 10;
	localparam int B_ITB     = 9;
	localparam int B_MDCS    = 8;
	localparam int B_DTC     = 6;
	localparam int B_COMP_POLARITY_BIT    = 5;
	localparam int B_CAM     = 2;
	localparam int B_EXTERNAL_PERIOD_RESET_ENABLE   = 1;
	localparam int B_IUE     = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h1FE7;
	localparam logic [15:0] DT_MASK    = 16'h3FFF;
	localparam logic [15:0] TRGC_MASK  = 16'hF03F;

	// Pin control register fields.
	localparam int B_HIGH_PIN_OWNERSHIP = 15;
	localparam int B_LOW_PIN_OWNERSHIP = 14;
	localparam int B_HIGH_PIN_POLARITY = 13;
	localparam int B_POLL = 12;
	localparam int B_PIN_PAIR_MODE = 10;
	localparam int B_OVRH = 9;
	localparam int B_OVRL = 8;
	localparam int B_OVRD = 6;
	localparam int B_FLTD = 4;
	localparam int B_CLD  = 2;
	localparam int B_SWAP = 1;
	localparam int B_OSYN = 0;
	localparam logic [15:0] IOC_RESET = 16'hC000;

	localparam logic [1:0] PIN_PAIR_MODE_COMP = 2'h0;
	localparam logic [1:0] PIN_PAIR_MODE_RED  = 2'h1;
	localparam logic [1:0] PIN_PAIR_MODE_PP   = 2'h2;
	localparam logic [1:0] DTC_POS   = 2'h0;
	localparam logic [1:0] DTC_COMP  = 2'h3;

	typedef struct packed {
		logic hi;
		logic lo;
	} pcg_pins_t;
endpackage : pcg_pkg

/* File: design/pcg_generator.sv */
// One PWM generator with time base, dead time, trigger and output stage behind Avalon-MM.
// How it works
// R01 - Compensation polarity clear: input 0 shortens high output, input 1 shortens low.
// R02 - Center alignment bit works only with the independent time base.
// R03 - Current-limit input resets independent time base when external reset enabled.
// R04 - Software sets independent time base and keeps current-limit mode off for this.
// R05 - Immediate update bit makes timing writes active at once, else at period boundary.
// R06 - Software keeps mode bits fixed while the module is enabled.
// R07 - Compensation polarity matters only when dead-time control equals 11.
// R08 - Phase register is phase shift, or the period with independent time base.
// R09 - Both dead-time values are 14 bits; upper two bits read zero.
// R10 - Trigger divider emits one trigger every N+1 trigger events.
// R11 - First trigger waits the start-delay count of PWM cycles after enable.
// R12 - A secondary generator never raises trigger status.
// R13 - Pin ownership bits give pins to PWM when 1; both reset to 1.
// R14 - Polarity bit makes its pin active low when set.
// R15 - Pair mode 00 complementary, 01 redundant, 10 push-pull.
// R16 - Override enables drive pins from override data bits.
// R17 - Active fault forces pins to fault data bits.
// R18 - Active current limit with its mode on forces pins to limit data.
// R19 - Swap bit exchanges high and low signals between pins.
// R20 - Override sync bit applies overrides at the PWM boundary, else at once.
// R21 - With write lock set, pin control writes need the unlock sequence first.
// R22 - Primary generator compares trigger value with its time base to fire triggers.
// R23 - Boundary-synchronised writes sit in shadows and copy together at the boundary.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module pcg_generator
	import pcg_pkg::*;
#(
	parameter bit          IS_SECONDARY = 1'b0,
	parameter logic [15:0] UNLOCK_KEY1  = 16'h5A5A, // Arbitrary value.
	parameter logic [15:0] UNLOCK_KEY2  = 16'hA5A5  // Arbitrary value.
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic [5:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        pwm_tick_in,
	input  wire logic        module_pwm_enable_in,
	input  wire logic [15:0] master_period_in,
	input  wire logic        master_boundary_in,
	input  wire logic        comp_direction_input_in,
	input  wire logic        fault_active_in,
	input  wire logic        limit_active_in,
	input  wire logic        current_limit_mode_enable_in,
	input  wire logic        config_write_lock_in,
	output pcg_pins_t        pin_data_out,
	output pcg_pins_t        pin_oe_out,
	output logic             adc_trigger_out
);
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [15:0] ctrl_q, duty_q, phase_q, dt_q, altdt_q, trgc_q, ioc_q, trig_q, mduty_q;
	logic [15:0] duty_act_q, phase_act_q, dt_act_q, altdt_act_q, mduty_act_q;
	logic [2:0]  stat_q;
	logic [1:0]  unlk_q;
	logic [15:0] tb_q;
	logic        down_q, pp_q;
	logic [5:0]  start_q;
	logic [3:0]  div_q;
	logic [3:0]  ovr_q;
	logic        wr, rd, bound, center, raw, tb_clr, trg_evt, trg_fire, shorten_h;
	logic [15:0] wmask, period, duty_sel;
	logic [13:0] dly_h, dly_l;
	pcg_pins_t   gen, dtd, swp, lvl;

	assign wr    = avs_write_in & ack_q;
	assign rd    = avs_read_in & ~ack_q;
	assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_readdata_out    = rdata_q;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m,
		input logic [15:0] d);
		merge = (old & ~m) | (d & m);
	endfunction : merge

	// Every access waits exactly one cycle, so the bus answer is fixed.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd) begin
			unique case (avs_address_in)
				OFS_CTRL:  rdata_q <= {16'h0000, stat_q, ctrl_q[12:0] & CTRL_WMASK[12:0]};
				OFS_DUTY:  rdata_q <= {16'h0000, duty_q};
				OFS_PHASE: rdata_q <= {16'h0000, phase_q};
				OFS_DT:    rdata_q <= {16'h0000, dt_q & DT_MASK}; // R09
				OFS_ALTDT: rdata_q <= {16'h0000, altdt_q & DT_MASK}; // R09
				OFS_TRGC:  rdata_q <= {16'h0000, trgc_q & TRGC_MASK};
				OFS_IOC:   rdata_q <= {16'h0000, ioc_q};
				OFS_TRIG:  rdata_q <= {16'h0000, trig_q};
				OFS_MDUTY: rdata_q <= {16'h0000, mduty_q};
				default:   rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Software-side copies; these are what a read returns.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ctrl_q  <= 16'h0000;
			duty_q  <= 16'h0000;
			phase_q <= 16'h0000;
			dt_q    <= 16'h0000;
			altdt_q <= 16'h0000;
			trgc_q  <= 16'h0000;
			trig_q  <= 16'h0000;
			mduty_q <= 16'h0000;
		end else if (wr) begin
			unique case (avs_address_in)
				OFS_CTRL:  ctrl_q  <= merge(ctrl_q, wmask & CTRL_WMASK, avs_writedata_in[15:0]);
				OFS_DUTY:  duty_q  <= merge(duty_q, wmask, avs_writedata_in[15:0]);
				OFS_PHASE: phase_q <= merge(phase_q, wmask, avs_writedata_in[15:0]);
				OFS_DT:    dt_q    <= merge(dt_q, wmask & DT_MASK, avs_writedata_in[15:0]); // R09
				OFS_ALTDT: altdt_q <= merge(altdt_q, wmask & DT_MASK, avs_writedata_in[15:0]);
				OFS_TRGC:  trgc_q  <= merge(trgc_q, wmask & TRGC_MASK, avs_writedata_in[15:0]);
				OFS_TRIG:  trig_q  <= merge(trig_q, wmask, avs_writedata_in[15:0]);
				OFS_MDUTY: mduty_q <= merge(mduty_q, wmask, avs_writedata_in[15:0]);
				default: ;
			endcase
		end
	end

	// Two-key unlock; it grants a single pin control write and is then spent.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			unlk_q <= 2'h0;
			ioc_q  <= IOC_RESET; // R13
		end else if (wr && avs_address_in == OFS_UNLK) begin
			unlk_q <= (avs_writedata_in[15:0] == UNLOCK_KEY1) ? 2'h1 :
				(unlk_q == 2'h1 && avs_writedata_in[15:0] == UNLOCK_KEY2) ? 2'h2 : 2'h0;
		end else if (wr && avs_address_in == OFS_IOC) begin
			if (!config_write_lock_in || unlk_q == 2'h2) begin // R21
				ioc_q <= merge(ioc_q, wmask, avs_writedata_in[15:0]);
			end
			unlk_q <= 2'h0;
		end
	end

	locked_io_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R21
		wr && avs_address_in == OFS_IOC && config_write_lock_in && unlk_q != 2'h2
		|=> $stable(ioc_q)) else $error("Locked pin control register was written.");
	own_reset_a: assert property (@(posedge clk_sys_in) // R13
		rst_in |=> ioc_q[B_HIGH_PIN_OWNERSHIP] && ioc_q[B_LOW_PIN_OWNERSHIP]) else $error("Pin ownership not set by reset.");
	dt_upper_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R09
		rd && avs_address_in == OFS_DT |=> rdata_q[31:14] == 18'h0_0000)
		else $error("Dead-time upper bits not zero.");

	// Active copies load together: at once when immediate or while disabled, else at the boundary.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			duty_act_q  <= 16'h0000;
			phase_act_q <= 16'h0000;
			dt_act_q    <= 16'h0000;
			altdt_act_q <= 16'h0000;
			mduty_act_q <= 16'h0000;
		end else if (ctrl_q[B_IUE] || bound || !module_pwm_enable_in) begin // R05 R23
			duty_act_q  <= duty_q;
			phase_act_q <= phase_q;
			dt_act_q    <= dt_q;
			altdt_act_q <= altdt_q;
			mduty_act_q <= mduty_q;
		end
	end

	shadow_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R23
		!ctrl_q[B_IUE] && !bound && module_pwm_enable_in |=> $stable(duty_act_q))
		else $error("Active duty changed between boundaries.");
	imm_update_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R05
		ctrl_q[B_IUE] && wr && avs_address_in == OFS_DUTY && avs_byteenable_in[1:0] == 2'h3
		##1 1'b1 |=> duty_act_q == $past(avs_writedata_in[15:0], 2))
		else $error("Immediate duty write not active.");

	// Time base.
	assign center = ctrl_q[B_CAM] & ctrl_q[B_ITB]; // R02
	assign period = ctrl_q[B_ITB] ? phase_act_q : master_period_in; // R08
	assign tb_clr = ctrl_q[B_EXTERNAL_PERIOD_RESET_ENABLE] & ctrl_q[B_ITB] & limit_active_in; // R03
	assign bound  = pwm_tick_in & module_pwm_enable_in &
		(center ? (down_q && tb_q == 16'h0000) : (tb_q >= period));

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !module_pwm_enable_in) begin
			tb_q   <= 16'h0000;
			down_q <= 1'b0;
		end else if (pwm_tick_in) begin
			if (tb_clr) begin
				tb_q   <= 16'h0000; // R03
				down_q <= 1'b0;
			end else if (!ctrl_q[B_ITB] && master_boundary_in) begin
				tb_q <= phase_act_q; // R08
			end else if (!center) begin
				tb_q   <= (tb_q >= period) ? 16'h0000 : 16'(tb_q + 16'h0001);
				down_q <= 1'b0;
			end else if (!down_q) begin // R02
				down_q <= tb_q >= period;
				tb_q   <= (tb_q >= period) ? 16'(tb_q - 16'h0001) : 16'(tb_q + 16'h0001);
			end else begin
				down_q <= tb_q != 16'h0000;
				tb_q   <= (tb_q == 16'h0000) ? 16'h0001 : 16'(tb_q - 16'h0001);
			end
		end
	end

	edge_only_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R02
		!ctrl_q[B_ITB] |=> !down_q) else $error("Counting down without independent time base.");
	ext_reset_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R03
		module_pwm_enable_in && pwm_tick_in && tb_clr |=> tb_q == 16'h0000)
		else $error("Current limit did not reset time base.");

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pp_q <= 1'b0;
		end else if (bound) begin
			pp_q <= ~pp_q;
		end
	end

	assign duty_sel = ctrl_q[B_MDCS] ? mduty_act_q : duty_act_q;
	assign raw      = module_pwm_enable_in & (tb_q < duty_sel);

	always_comb begin
		unique case (ioc_q[B_PIN_PAIR_MODE +: 2]) // R15
			PIN_PAIR_MODE_RED: gen = '{hi: raw, lo: raw};
			PIN_PAIR_MODE_PP:  gen = '{hi: raw & pp_q, lo: raw & ~pp_q};
			default:  gen = '{hi: raw, lo: module_pwm_enable_in & ~raw};
		endcase
	end

	// Dead time delays each rising edge; compensation shortens only one side.
	assign shorten_h = ~(comp_direction_input_in ^ ctrl_q[B_COMP_POLARITY_BIT]); // R01
	always_comb begin
		dly_h = 14'h0000;
		dly_l = 14'h0000;
		if (ctrl_q[B_DTC +: 2] == DTC_POS) begin
			dly_h = dt_act_q[13:0];
			dly_l = altdt_act_q[13:0];
		end else if (ctrl_q[B_DTC +: 2] == DTC_COMP) begin // R07
			dly_h = shorten_h ? dt_act_q[13:0] : 14'h0000; // R01
			dly_l = shorten_h ? 14'h0000 : dt_act_q[13:0];
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_dead
		logic [13:0] cnt_q;
		logic        src;
		logic [13:0] dly;
		assign src = i ? gen.hi : gen.lo;
		assign dly = i ? dly_h : dly_l;
		always_ff @(posedge clk_sys_in) begin
			if (rst_in || !src) begin
				cnt_q <= 14'h0000;
			end else if (pwm_tick_in && cnt_q != 14'h3FFF) begin
				cnt_q <= 14'(cnt_q + 14'h0001);
			end
		end
		if (i) begin : g_h
			assign dtd.hi = src & (cnt_q >= dly);
		end else begin : g_l
			assign dtd.lo = src & (cnt_q >= dly);
		end
	end

	assign swp = ioc_q[B_SWAP] ? '{hi: dtd.lo, lo: dtd.hi} : dtd; // R19

	// Override state, either taken at once or held to the boundary.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ovr_q <= 4'h0;
		end else if (!ioc_q[B_OSYN] || bound || !module_pwm_enable_in) begin // R20
			ovr_q <= {ioc_q[B_OVRH], ioc_q[B_OVRL], ioc_q[B_OVRD +: 2]};
		end
	end

	// Fault outranks current limit, which outranks software override.
	always_comb begin
		lvl = swp;
		if (fault_active_in) begin
			lvl = '{hi: ioc_q[B_FLTD + 1], lo: ioc_q[B_FLTD]}; // R17
		end else if (limit_active_in && current_limit_mode_enable_in) begin
			lvl = '{hi: ioc_q[B_CLD + 1], lo: ioc_q[B_CLD]}; // R18
		end else begin
			if (ovr_q[3]) lvl.hi = ovr_q[1]; // R16
			if (ovr_q[2]) lvl.lo = ovr_q[0]; // R16
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pin_data_out <= '{hi: 1'b0, lo: 1'b0};
		end else begin
			pin_data_out.hi <= ioc_q[B_HIGH_PIN_OWNERSHIP] & (lvl.hi ^ ioc_q[B_HIGH_PIN_POLARITY]); // R13 R14
			pin_data_out.lo <= ioc_q[B_LOW_PIN_OWNERSHIP] & (lvl.lo ^ ioc_q[B_POLL]); // R13 R14
		end
	end
	assign pin_oe_out = '{hi: ioc_q[B_HIGH_PIN_OWNERSHIP], lo: ioc_q[B_LOW_PIN_OWNERSHIP]}; // R13

	fault_force_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R17
		fault_active_in && ioc_q[B_HIGH_PIN_OWNERSHIP] |=>
		pin_data_out.hi == $past(ioc_q[B_FLTD + 1] ^ ioc_q[B_HIGH_PIN_POLARITY]))
		else $error("Fault did not force high pin.");
	override_lo_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R16
		!fault_active_in && !limit_active_in && ovr_q[2] && ioc_q[B_LOW_PIN_OWNERSHIP] |=>
		pin_data_out.lo == $past(ovr_q[0] ^ ioc_q[B_POLL]))
		else $error("Override did not drive low pin.");

	// Trigger start delay, compare and divider.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !module_pwm_enable_in) begin
			start_q <= 6'h00;
		end else if (bound && start_q != trgc_q[5:0]) begin
			start_q <= 6'(start_q + 6'h01); // R11
		end
	end

	assign trg_evt  = pwm_tick_in & module_pwm_enable_in & ~IS_SECONDARY // R22
		& (start_q == trgc_q[5:0]) & (tb_q == trig_q); // R11
	assign trg_fire = trg_evt & (div_q == trgc_q[15:12]); // R10

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !module_pwm_enable_in) begin
			div_q           <= 4'h0;
			adc_trigger_out <= 1'b0;
		end else begin
			adc_trigger_out <= trg_fire;
			if (trg_evt) begin
				div_q <= trg_fire ? 4'h0 : 4'(div_q + 4'h1); // R10
			end
		end
	end

	// Status bits clear while their enable is low; a set needs the enable.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			stat_q <= 3'h0;
		end else begin
			stat_q[2] <= ctrl_q[B_FLTIEN] & (stat_q[2] | fault_active_in);
			stat_q[1] <= ctrl_q[B_CLIEN] & (stat_q[1] | limit_active_in);
			stat_q[0] <= ~IS_SECONDARY & ctrl_q[B_TRGIEN] & (stat_q[0] | trg_fire); // R12
		end
	end

	div_count_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
		trg_evt && !trg_fire |=> div_q == $past(div_q) + 4'h1)
		else $error("Trigger divider did not advance.");
	start_wait_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R11
		trg_fire |-> start_q == trgc_q[5:0]) else $error("Trigger before start delay ran out.");
	no_sec_trig_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R12
		IS_SECONDARY |-> !stat_q[0] && !adc_trigger_out) else $error("Secondary raised trigger.");
endmodule : pcg_generator
`default_nettype wire

/* File: dv/pcg_power_stage.sv */
// Behavioural power stage that turns the generator's pin pair into gate levels.
`timescale 1ns/100ps
`default_nettype none
module pcg_power_stage
	import pcg_pkg::*;
(
	input  wire pcg_pins_t pin_data_in,
	input  wire pcg_pins_t pin_oe_in,
	output logic           hi_level_out,
	output logic           lo_level_out
);
	// A released pin is held off by the gate driver's pull-down, so it never turns a switch on.
	assign hi_level_out = pin_oe_in.hi ? pin_data_in.hi : 1'b0;
	assign lo_level_out = pin_oe_in.lo ? pin_data_in.lo : 1'b0;
endmodule : pcg_power_stage
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for a primary and a secondary PWM generator: registers, output stage, lock and triggers.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pcg_pkg::*;
	localparam logic [15:0] KEY1 = 16'h3C3C; // Arbitrary value.
	localparam logic [15:0] KEY2 = 16'hC3C3; // Arbitrary value.
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic [5:0]  bus_addr   = 6'h00;
	logic        bus_rd     = 1'b0;
	logic        bus_wr     = 1'b0;
	logic [31:0] bus_wdata  = 32'h0000_0000;
	logic        pwm_en     = 1'b0;
	logic        fault      = 1'b0;
	logic        limit      = 1'b0;
	logic        lim_mode   = 1'b0;
	logic        lock       = 1'b0;
	logic [3:0]  bus_be     = 4'h3;
	logic        tick       = 1'b1;
	logic [15:0] m_period   = 16'h0040;
	logic        m_bound    = 1'b0;
	logic        comp_dir   = 1'b0;
	logic [31:0] rdata_w;
	logic        wait_w;
	logic        adc_w;
	logic        sec_trig_w;
	logic        hi_lvl;
	logic        lo_lvl;
	pcg_pins_t   pin_data_w;
	pcg_pins_t   pin_oe_w;
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          cycles    = 0;
	int          sec_cnt   = 0;
	int          f0, g0, f, g;

	always #2 clk_sys_in = ~clk_sys_in;

	pcg_generator #(.IS_SECONDARY(1'b0), .UNLOCK_KEY1(KEY1), .UNLOCK_KEY2(KEY2)) pcg_generator_i (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(bus_addr),
		.avs_read_in(bus_rd), .avs_write_in(bus_wr), .avs_writedata_in(bus_wdata),
		.avs_byteenable_in(bus_be), .avs_readdata_out(rdata_w), .avs_waitrequest_out(wait_w),
		.pwm_tick_in(tick), .module_pwm_enable_in(pwm_en), .master_period_in(m_period),
		.master_boundary_in(m_bound), .comp_direction_input_in(comp_dir), .fault_active_in(fault),
		.limit_active_in(limit), .current_limit_mode_enable_in(lim_mode),
		.config_write_lock_in(lock), .pin_data_out(pin_data_w), .pin_oe_out(pin_oe_w),
		.adc_trigger_out(adc_w));

	pcg_generator #(.IS_SECONDARY(1'b1), .UNLOCK_KEY1(KEY1), .UNLOCK_KEY2(KEY2)) pcg_generator_sec_i (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(bus_addr),
		.avs_read_in(bus_rd), .avs_write_in(bus_wr), .avs_writedata_in(bus_wdata),
		.avs_byteenable_in(bus_be), .avs_readdata_out(), .avs_waitrequest_out(),
		.pwm_tick_in(tick), .module_pwm_enable_in(pwm_en), .master_period_in(m_period),
		.master_boundary_in(m_bound), .comp_direction_input_in(comp_dir), .fault_active_in(fault),
		.limit_active_in(limit), .current_limit_mode_enable_in(lim_mode),
		.config_write_lock_in(lock), .pin_data_out(), .pin_oe_out(),
		.adc_trigger_out(sec_trig_w));

	pcg_power_stage pcg_power_stage_i (
		.pin_data_in(pin_data_w), .pin_oe_in(pin_oe_w),
		.hi_level_out(hi_lvl), .lo_level_out(lo_lvl));

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	always @(negedge clk_sys_in) begin
		if (sec_trig_w === 1'b1) begin
			sec_cnt++;
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask : check

	// Waitrequest is sampled at each rising edge; the edge that sees it low completes the
	// transfer and carries the read data, and only after it is the request dropped.
	task automatic bus_cycle(input logic [5:0] a, input logic w, input logic [15:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_in);
		bus_addr  <= a;
		bus_wdata <= {16'h0000, d};
		bus_wr    <= w;
		bus_rd    <= !w;
		do begin
			@(posedge clk_sys_in);
		end while (wait_w !== 1'b0);
		q = rdata_w;
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
	endtask : bus_cycle

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus_cycle(a, 1'b1, d, q);
	endtask : wr

	task automatic rdchk(input string name, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus_cycle(a, 1'b0, 16'h0000, q);
		check(name, q, exp);
	endtask : rdchk

	task automatic pins(input string name, input logic [1:0] exp);
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(name, {30'h0, hi_lvl, lo_lvl}, {30'h0, exp});
	endtask : pins

	task automatic meas(output int first, output int gap);
		int n;
		@(posedge clk_sys_in);
		pwm_en <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (adc_w !== 1'b1 && n < 2000);
		first = n;
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (adc_w !== 1'b1 && n < 2000);
		gap = n;
		@(posedge clk_sys_in);
		pwm_en <= 1'b0;
	endtask : meas

	// Counts high cycles of each gate level over ten whole periods of eleven ticks.
	task automatic duty(input string name, input int exp_hi, input int exp_lo);
		int nh, nl;
		@(posedge clk_sys_in);
		pwm_en <= 1'b1;
		nh = 0;
		nl = 0;
		repeat (22) @(posedge clk_sys_in);
		repeat (110) begin
			@(negedge clk_sys_in);
			nh += (hi_lvl === 1'b1);
			nl += (lo_lvl === 1'b1);
		end
		@(posedge clk_sys_in);
		pwm_en <= 1'b0;
		check({name, "_hi"}, 32'(nh), 32'(exp_hi));
		check({name, "_lo"}, 32'(nl), 32'(exp_lo));
	endtask : duty

	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rdchk("ioc_reset", OFS_IOC, 32'h0000_C000);
		check("oe_reset", {30'h0, pin_oe_w}, 32'h0000_0003);
		$display("test reset done");
		wr(OFS_DT, 16'hFFFF);
		rdchk("dt_mask", OFS_DT, 32'h0000_3FFF);
		wr(OFS_ALTDT, 16'hFFFF);
		rdchk("altdt_mask", OFS_ALTDT, 32'h0000_3FFF);
		wr(OFS_TRGC, 16'hFFFF);
		rdchk("trgc_mask", OFS_TRGC, 32'h0000_F03F);
		wr(OFS_CTRL, 16'hFFFF);
		rdchk("ctrl_mask", OFS_CTRL, {16'h0000, CTRL_WMASK});
		wr(6'h3C, 16'hFFFF);
		rdchk("unmapped", 6'h3C, 32'h0000_0000);
		@(posedge clk_sys_in);
		bus_be <= 4'h1;
		wr(OFS_TRIG, 16'hABCD);
		bus_be <= 4'h3;
		rdchk("byte_lane", OFS_TRIG, 32'h0000_00CD);
		for (int m = 0; m < 3; m++) begin
			wr(OFS_IOC, 16'hC000 | (16'(m) << B_PIN_PAIR_MODE));
			rdchk("pin_pair_mode", OFS_IOC, {16'h0000, 16'hC000 | (16'(m) << B_PIN_PAIR_MODE)});
		end
		$display("test registers done");
		wr(OFS_IOC, 16'hC380);
		pins("override", 2'b10);
		wr(OFS_IOC, 16'hF380);
		pins("polarity", 2'b01);
		wr(OFS_IOC, 16'h4380);
		pins("ownership", 2'b00);
		check("oe_own", {30'h0, pin_oe_w}, 32'h0000_0001);
		wr(OFS_IOC, 16'hC318);
		@(posedge clk_sys_in);
		fault    <= 1'b1;
		limit    <= 1'b1;
		lim_mode <= 1'b1;
		pins("fault", 2'b01);
		@(posedge clk_sys_in);
		fault <= 1'b0;
		pins("limit", 2'b10);
		@(posedge clk_sys_in);
		lim_mode <= 1'b0;
		pins("limit_off", 2'b00);
		@(posedge clk_sys_in);
		limit <= 1'b0;
		$display("test output stage done");
		@(posedge clk_sys_in);
		lock <= 1'b1;
		wr(OFS_IOC, 16'hC080);
		rdchk("locked", OFS_IOC, 32'h0000_C318);
		wr(OFS_UNLK, KEY1);
		wr(OFS_UNLK, KEY2);
		wr(OFS_IOC, 16'hC080);
		rdchk("unlocked", OFS_IOC, 32'h0000_C080);
		wr(OFS_IOC, 16'hC000);
		rdchk("relocked", OFS_IOC, 32'h0000_C080);
		@(posedge clk_sys_in);
		lock <= 1'b0;
		$display("test lock done");
		wr(OFS_CTRL, 16'h0201);
		wr(OFS_PHASE, 16'h000A);
		wr(OFS_TRIG, 16'h0002);
		wr(OFS_TRGC, 16'h0000);
		meas(f0, g0);
		wr(OFS_TRGC, 16'h2000);
		meas(f, g);
		check("div3", 32'(g), 32'(3 * g0));
		wr(OFS_TRGC, 16'hF000);
		meas(f, g);
		check("div16", 32'(g), 32'(16 * g0));
		wr(OFS_TRGC, 16'h0003);
		meas(f, g);
		check("start", 32'(f), 32'(f0 + 3 * g0));
		wr(OFS_TRGC, 16'h0000);
		wr(OFS_PHASE, 16'h0014);
		meas(f, g);
		check("period", 32'(g), 32'(g0 + 10));
		wr(OFS_CTRL, 16'h0001);
		meas(f, g);
		check("master", 32'(g), 32'(m_period + 16'h0001));
		wr(OFS_PHASE, 16'h0002);
		@(posedge clk_sys_in);
		m_bound <= 1'b1;
		meas(f, g);
		check("phase_load", 32'(g), 32'h0000_0001);
		m_bound <= 1'b0;
		wr(OFS_CTRL, 16'h0203);
		wr(OFS_TRIG, 16'h0000);
		@(posedge clk_sys_in);
		limit <= 1'b1;
		meas(f, g);
		check("ext_reset", 32'(g), 32'h0000_0001);
		limit <= 1'b0;
		check("secondary", 32'(sec_cnt), 32'h0000_0000);
		$display("test triggers done");
		wr(OFS_PHASE, 16'h000A);
		wr(OFS_CTRL, 16'h0281);
		wr(OFS_DUTY, 16'h0005);
		wr(OFS_IOC, 16'hC000);
		duty("comp", 50, 60);
		wr(OFS_IOC, 16'hC002);
		duty("swap", 60, 50);
		wr(OFS_IOC, 16'hC400);
		duty("redundant", 50, 50);
		wr(OFS_IOC, 16'hC000);
		wr(OFS_CTRL, 16'h02C1);
		wr(OFS_DT, 16'h0002);
		duty("dt_comp0", 30, 60);
		@(posedge clk_sys_in);
		comp_dir <= 1'b1;
		duty("dt_comp1", 50, 40);
		wr(OFS_CTRL, 16'h0381);
		wr(OFS_MDUTY, 16'h0008);
		duty("master_duty", 80, 30);
		$display("test waveforms done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
